// file: asl_pkg.sv
// Shared constants and carrier types of the alert status latch bank.
// Assumes a 32-bit APB master and asynchronous comparator flags from the analog side.
package asl_pkg;

    // Bus geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] LIVE_OFF    = 8'h00;
    localparam logic [7:0] LATCH_A_OFF = 8'h04;
    localparam logic [7:0] LATCH_B_OFF = 8'h08;
    localparam logic [7:0] IRQ_ST_OFF  = 8'h0c;
    localparam logic [7:0] IRQ_MSK_OFF = 8'h10;

    // Reset values
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [10:0] IRQ_RST    = 11'h000;

    // Alert vector: group a in [6:0], group b in [9:7]
    localparam int NUM_ALERT = 10;
    localparam int A_W       = 7;
    localparam int B_W       = 3;
    localparam int B_BASE    = 7;

    // Group a bit positions
    localparam int RAIL_ONE_OC  = 0;
    localparam int RAIL_TWO_OC  = 1;
    localparam int LED_UV       = 2;
    localparam int LED_OV       = 3;
    localparam int LED_WARN     = 4;
    localparam int LED_TSD      = 5;
    localparam int CHIP_WARN    = 6;

    // Group b bit positions
    localparam int RAIL_TWO_DESAT = 0;
    localparam int LED_DESAT      = 1;
    localparam int LED_OC         = 2;

    // Interrupt layout: group a in [6:0], group b from bit 8
    localparam int IRQ_W       = 11;
    localparam int IRQ_B_SHIFT = 8;

    // Synchroniser depth for comparator pins
    localparam int SYNC_DEPTH = 3;

    // Bus slave states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RESP = 3'b010,
        ST_SPARE = 3'b100
    } asl_state_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } asl_apb_req_t;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } asl_apb_rsp_t;

    // Raw comparator flags, one bit per alert in alert-vector order
    typedef struct packed {
        logic [NUM_ALERT-1:0] trip;
        logic [NUM_ALERT-1:0] hold;
    } asl_cmp_t;

endpackage

// file: asl_alert_hyst.sv
// One alert flag: pin synchronisers and a set/hold hysteresis latch.
// Assumes trip and hold come straight from asynchronous comparator pins.
`timescale 1ns/10ps
module asl_alert_hyst (
    input  wire logic sys_clk_i,
    input  wire logic nrst_i,
    input  wire logic trip_i,
    input  wire logic hold_i,
    output logic      alert_o
);
    logic [2:0] trip_sync_reg;
    logic [2:0] hold_sync_reg;
    logic       trip_reg;
    logic       hold_reg;
    logic       alert_reg;
    logic       alert_next;

    // Three stages; only stage two and three are looked at
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            trip_sync_reg <= 3'h0;
            hold_sync_reg <= 3'h0;
        end else begin
            trip_sync_reg <= {trip_sync_reg[1:0], trip_i};
            hold_sync_reg <= {hold_sync_reg[1:0], hold_i};
        end
    end

    // Accept a change only when the last two stages agree, a cheap glitch filter
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            trip_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            if (trip_sync_reg[1] == trip_sync_reg[2]) trip_reg <= trip_sync_reg[2];
            if (hold_sync_reg[1] == hold_sync_reg[2]) hold_reg <= hold_sync_reg[2];
        end
    end

    // Set above threshold, stay while above threshold minus hysteresis
    assign alert_next = trip_reg | (alert_reg & hold_reg);

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) alert_reg <= 1'b0;
        else         alert_reg <= alert_next;
    end

    assign alert_o = alert_reg;

    a_trip_sets: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        trip_reg |=> alert_reg)
        else $error("alert not set after trip");

    a_band_holds: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (alert_reg && hold_reg) |=> alert_reg)
        else $error("alert dropped inside hysteresis band");

    a_low_clears: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (!trip_reg && !hold_reg) |=> !alert_reg)
        else $error("alert kept below release level");

endmodule

// file: asl_alert_status_bank.sv
// Alert status bank: live view of the group b faults, two rising-edge sticky latches,
// fast shutdown outputs and a maskable interrupt, all behind an APB slave.
// Assumes one 50 MHz clock, a synchronous active-low reset and async comparator pins.
`timescale 1ns/10ps
module asl_alert_status_bank (
    input  wire logic                  sys_clk_i,
    input  wire logic                  nrst_i,
    input  wire asl_pkg::asl_apb_req_t apb_req_i,
    output asl_pkg::asl_apb_rsp_t      apb_rsp_o,
    input  wire asl_pkg::asl_cmp_t     cmp_i,
    output logic                       led_driver_off_o,
    output logic                       second_converter_off_o,
    output logic                       irq_o
);

    // Address match, used for every register select
    function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
        reg_hit = (addr == {24'h000000, off});
    endfunction

    logic [asl_pkg::NUM_ALERT-1:0] hold_v;
    logic [asl_pkg::NUM_ALERT-1:0] alert_v;
    logic [asl_pkg::NUM_ALERT-1:0] alert_prev_reg;
    logic [asl_pkg::NUM_ALERT-1:0] rise_v;
    logic [asl_pkg::A_W-1:0]       alert_a;
    logic [asl_pkg::B_W-1:0]       alert_b;
    logic [asl_pkg::A_W-1:0]       rise_a;
    logic [asl_pkg::B_W-1:0]       rise_b;
    logic [asl_pkg::A_W-1:0]       latch_a_reg;
    logic [asl_pkg::A_W-1:0]       latch_a_next;
    logic [asl_pkg::B_W-1:0]       latch_b_reg;
    logic [asl_pkg::B_W-1:0]       latch_b_next;
    logic [asl_pkg::A_W-1:0]       clr_a;
    logic [asl_pkg::B_W-1:0]       clr_b;
    logic [asl_pkg::IRQ_W-1:0]     irq_st_reg;
    logic [asl_pkg::IRQ_W-1:0]     irq_st_next;
    logic [asl_pkg::IRQ_W-1:0]     irq_msk_reg;
    logic [asl_pkg::IRQ_W-1:0]     irq_ev;
    logic [asl_pkg::IRQ_W-1:0]     irq_w1c;
    logic                          led_off_reg;
    logic                          conv_off_reg;
    asl_pkg::asl_state_t           state_reg;
    asl_pkg::asl_state_t           state_next;
    logic [31:0]                   prdata_reg;
    logic                          slverr_reg;
    logic [31:0]                   rd_word;
    logic                          sel_live;
    logic                          sel_a;
    logic                          sel_b;
    logic                          sel_st;
    logic                          sel_msk;
    logic                          mapped;
    logic                          access;
    logic                          cap_en;
    logic                          done;
    logic                          rd_done;
    logic                          wr_done;

    // Hold inputs: hysteresis alerts use their own release comparator
    assign hold_v[asl_pkg::LED_TSD] = cmp_i.hold[asl_pkg::LED_TSD];
    assign hold_v[asl_pkg::LED_WARN] = cmp_i.hold[asl_pkg::LED_WARN];
    assign hold_v[asl_pkg::LED_OV]  = cmp_i.hold[asl_pkg::LED_OV];
    // Undervoltage: trip is below the low level, hold is still below threshold
    assign hold_v[asl_pkg::LED_UV]  = cmp_i.hold[asl_pkg::LED_UV];
    assign hold_v[asl_pkg::RAIL_TWO_OC] = cmp_i.hold[asl_pkg::RAIL_TWO_OC];
    // Plain limits have no band, so hold simply repeats trip
    assign hold_v[asl_pkg::RAIL_ONE_OC] = cmp_i.trip[asl_pkg::RAIL_ONE_OC];
    assign hold_v[asl_pkg::CHIP_WARN] = cmp_i.trip[asl_pkg::CHIP_WARN];
    assign hold_v[asl_pkg::B_BASE+asl_pkg::RAIL_TWO_DESAT] =
        cmp_i.trip[asl_pkg::B_BASE+asl_pkg::RAIL_TWO_DESAT];
    assign hold_v[asl_pkg::B_BASE+asl_pkg::LED_DESAT] =
        cmp_i.trip[asl_pkg::B_BASE+asl_pkg::LED_DESAT];
    assign hold_v[asl_pkg::B_BASE+asl_pkg::LED_OC] =
        cmp_i.trip[asl_pkg::B_BASE+asl_pkg::LED_OC];

    // One synchronised, filtered flag per alert
    genvar g;
    generate
        for (g = 0; g < asl_pkg::NUM_ALERT; g++) begin : g_alert
            asl_alert_hyst u_alert (
                .sys_clk_i (sys_clk_i),
                .nrst_i    (nrst_i),
                .trip_i    (cmp_i.trip[g]),
                .hold_i    (hold_v[g]),
                .alert_o   (alert_v[g])
            );
        end
    endgenerate

    // Split into the two register groups
    assign alert_a = alert_v[asl_pkg::A_W-1:0];
    assign alert_b = alert_v[asl_pkg::NUM_ALERT-1:asl_pkg::B_BASE];

    // Edge detect against last cycle's alert state
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) alert_prev_reg <= '0;
        else         alert_prev_reg <= alert_v;
    end

    assign rise_v = alert_v & ~alert_prev_reg;
    assign rise_a = rise_v[asl_pkg::A_W-1:0];
    assign rise_b = rise_v[asl_pkg::NUM_ALERT-1:asl_pkg::B_BASE];

    // Bus decode
    assign sel_live = reg_hit(apb_req_i.paddr, asl_pkg::LIVE_OFF);
    assign sel_a    = reg_hit(apb_req_i.paddr, asl_pkg::LATCH_A_OFF);
    assign sel_b    = reg_hit(apb_req_i.paddr, asl_pkg::LATCH_B_OFF);
    assign sel_st   = reg_hit(apb_req_i.paddr, asl_pkg::IRQ_ST_OFF);
    assign sel_msk  = reg_hit(apb_req_i.paddr, asl_pkg::IRQ_MSK_OFF);
    assign mapped   = sel_live | sel_a | sel_b | sel_st | sel_msk;

    // Phase qualifiers; every access takes exactly one wait state
    assign access  = apb_req_i.psel & apb_req_i.penable;
    assign cap_en  = access & (state_reg == asl_pkg::ST_IDLE);
    assign done    = access & (state_reg == asl_pkg::ST_RESP);
    assign rd_done = done & ~apb_req_i.pwrite;
    assign wr_done = done & apb_req_i.pwrite & mapped;

    // Read mux; unused upper bits are zero
    // Sticky reads include this cycle's edges, so the clear that follows loses none
    assign rd_word =
        ({32{sel_live}} & {24'h000000, 5'h00, alert_b}) |
        ({32{sel_a}}    & {24'h000000, 1'b0, latch_a_reg | rise_a}) |
        ({32{sel_b}}    & {24'h000000, 5'h00, latch_b_reg | rise_b}) |
        ({32{sel_st}}   & {21'h000000, irq_st_reg}) |
        ({32{sel_msk}}  & {21'h000000, irq_msk_reg});

    // Slave state machine
    always_comb begin
        case (state_reg)
            asl_pkg::ST_IDLE: state_next = cap_en ? asl_pkg::ST_RESP : asl_pkg::ST_IDLE;
            asl_pkg::ST_RESP: state_next = done ? asl_pkg::ST_IDLE : asl_pkg::ST_RESP;
            default:          state_next = asl_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) state_reg <= asl_pkg::ST_IDLE;
        else         state_reg <= state_next;
    end

    // Read data is frozen one cycle before completion so it comes from a flop
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            prdata_reg <= 32'h00000000;
            slverr_reg <= 1'b0;
        end else if (cap_en) begin
            prdata_reg <= rd_word;
            slverr_reg <= ~mapped;
        end
    end

    assign apb_rsp_o.pready  = (state_reg == asl_pkg::ST_RESP);
    assign apb_rsp_o.pslverr = slverr_reg;
    assign apb_rsp_o.prdata  = prdata_reg;

    // Clear only what software actually saw, so a later edge survives
    assign clr_a = (rd_done & sel_a) ? prdata_reg[asl_pkg::A_W-1:0] : '0;
    assign clr_b = (rd_done & sel_b) ? prdata_reg[asl_pkg::B_W-1:0] : '0;

    // A fresh edge wins over the clear in the same cycle
    assign latch_a_next = (latch_a_reg & ~clr_a) | rise_a;
    assign latch_b_next = (latch_b_reg & ~clr_b) | rise_b;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            latch_a_reg <= asl_pkg::STATUS_RST[asl_pkg::A_W-1:0];
            latch_b_reg <= asl_pkg::STATUS_RST[asl_pkg::B_W-1:0];
        end else begin
            latch_a_reg <= latch_a_next;
            latch_b_reg <= latch_b_next;
        end
    end

    // Interrupt events share the sticky layout, group b shifted up
    assign irq_ev  = {rise_b, 1'b0, rise_a};
    assign irq_w1c = (wr_done & sel_st) ? apb_req_i.pwdata[asl_pkg::IRQ_W-1:0] : '0;
    assign irq_st_next = (irq_st_reg & ~irq_w1c) | irq_ev;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            irq_st_reg  <= asl_pkg::IRQ_RST;
            irq_msk_reg <= asl_pkg::IRQ_RST;
        end else begin
            irq_st_reg <= irq_st_next;
            if (wr_done & sel_msk) irq_msk_reg <= apb_req_i.pwdata[asl_pkg::IRQ_W-1:0];
        end
    end

    // Level output, high while any unmasked event is pending
    assign irq_o = |(irq_st_reg & irq_msk_reg);

    // Fast shutdowns follow the filtered alerts; pin filtering costs a few cycles
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            led_off_reg  <= 1'b0;
            conv_off_reg <= 1'b0;
        end else begin
            led_off_reg  <= alert_b[asl_pkg::LED_OC] |
                            alert_b[asl_pkg::LED_DESAT];
            conv_off_reg <= alert_b[asl_pkg::RAIL_TWO_DESAT];
        end
    end

    assign led_driver_off_o       = led_off_reg;
    assign second_converter_off_o = conv_off_reg;

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    a_live_read: assert property (
        (cap_en && sel_live) |=> (prdata_reg == {29'h00000000, $past(alert_b)}))
        else $error("live read does not match alert state");

    a_sticky_set: assert property (
        (rise_a != '0) |=> ((latch_a_reg & $past(rise_a)) == $past(rise_a)))
        else $error("group a edge not latched");

    a_led_oc_latch: assert property (
        rise_b[asl_pkg::LED_OC] |=> latch_b_reg[asl_pkg::LED_OC])
        else $error("led overcurrent edge not latched");

    a_led_oc_off: assert property (
        alert_b[asl_pkg::LED_OC] |=> led_driver_off_o)
        else $error("led driver not off on overcurrent");

    a_led_desat_off: assert property (
        $rose(alert_b[asl_pkg::LED_DESAT]) |=>
            (led_driver_off_o && latch_b_reg[asl_pkg::LED_DESAT]))
        else $error("led desaturation not handled");

    a_rail_desat_off: assert property (
        alert_b[asl_pkg::RAIL_TWO_DESAT] |=> second_converter_off_o)
        else $error("converter not off on desaturation");

    a_rail_desat_latch: assert property (
        rise_b[asl_pkg::RAIL_TWO_DESAT] |=> latch_b_reg[asl_pkg::RAIL_TWO_DESAT])
        else $error("rail two desaturation edge not latched");

    // An edge in a capture cycle is read out and may be cleared one cycle later
    a_chip_warn_latch: assert property (
        (rise_a[asl_pkg::CHIP_WARN] && !(cap_en && sel_a)) |=>
            latch_a_reg[asl_pkg::CHIP_WARN] [*2])
        else $error("chip warning edge lost");

    a_reserved_zero: assert property (
        (cap_en && (sel_live || sel_b)) |=> (prdata_reg[31:3] == 29'h00000000))
        else $error("reserved bits not zero");

    a_bit7_zero: assert property (
        (cap_en && sel_a) |=> (prdata_reg[7] == 1'b0))
        else $error("reserved bit seven of latch a set");

    a_read_clears: assert property (
        (rd_done && sel_a && (rise_a == '0)) |=>
            ((latch_a_reg & $past(prdata_reg[asl_pkg::A_W-1:0])) == '0))
        else $error("read did not clear latch a");

    a_read_keeps_edge: assert property (
        (rd_done && sel_b && (rise_b != '0)) |=>
            ((latch_b_reg & $past(rise_b)) == $past(rise_b)))
        else $error("edge lost during read clear");

    // Sticky bits only move on an edge or a completed read
    a_sticky_b_set: assert property (
        (rise_b != '0) |=> ((latch_b_reg & $past(rise_b)) == $past(rise_b)))
        else $error("group b edge not latched");

    a_hold_a: assert property (
        !(rd_done && sel_a) |=> ((latch_a_reg & $past(latch_a_reg)) == $past(latch_a_reg)))
        else $error("latch a bit dropped without a read");

    a_hold_b: assert property (
        !(rd_done && sel_b) |=> ((latch_b_reg & $past(latch_b_reg)) == $past(latch_b_reg)))
        else $error("latch b bit dropped without a read");

    a_set_by_edge_a: assert property (
        1'b1 |=> ((latch_a_reg & ~$past(latch_a_reg) & ~$past(rise_a)) == '0))
        else $error("latch a bit set without an edge");

    a_set_by_edge_b: assert property (
        1'b1 |=> ((latch_b_reg & ~$past(latch_b_reg) & ~$past(rise_b)) == '0))
        else $error("latch b bit set without an edge");

    a_read_clears_b: assert property (
        (rd_done && sel_b && (rise_b == '0)) |=>
            ((latch_b_reg & $past(prdata_reg[asl_pkg::B_W-1:0])) == '0))
        else $error("read did not clear latch b");

    a_read_keeps_edge_a: assert property (
        (rd_done && sel_a && (rise_a != '0)) |=>
            ((latch_a_reg & $past(rise_a)) == $past(rise_a)))
        else $error("edge lost during latch a read clear");

    // A capture-cycle edge reaches software, so clearing it loses nothing
    a_capture_shows_edge: assert property (
        (cap_en && sel_a) |=>
            ((prdata_reg[asl_pkg::A_W-1:0] & $past(rise_a)) == $past(rise_a)))
        else $error("capture-cycle edge missing from read data");

    // Shutdowns follow the flags both ways
    a_led_desat_level: assert property (
        alert_b[asl_pkg::LED_DESAT] |=> led_driver_off_o)
        else $error("led driver not off while desaturated");

    a_led_off_release: assert property (
        (!alert_b[asl_pkg::LED_OC] && !alert_b[asl_pkg::LED_DESAT]) |=>
            !led_driver_off_o)
        else $error("led driver held off without a fault");

    a_conv_off_release: assert property (
        !alert_b[asl_pkg::RAIL_TWO_DESAT] |=> !second_converter_off_o)
        else $error("converter held off without a fault");

    // Reset check has to run while the default disable is active
    a_reset_clears: assert property (disable iff (1'b0)
        !nrst_i |=> ((latch_a_reg == '0) && (latch_b_reg == '0) &&
            (irq_st_reg == '0) && (prdata_reg == 32'h00000000)))
        else $error("status not cleared by reset");

    // Bus answers
    a_slverr_unmapped: assert property (
        (cap_en && !mapped) |=>
            (apb_rsp_o.pslverr && (apb_rsp_o.prdata == 32'h00000000)))
        else $error("unmapped access not refused");

    a_state_legal: assert property (
        (state_reg == asl_pkg::ST_IDLE) || (state_reg == asl_pkg::ST_RESP))
        else $error("bus state machine left its legal states");

    a_pready_once: assert property (
        cap_en |=> (apb_rsp_o.pready ##1 !apb_rsp_o.pready))
        else $error("pready not a single cycle after capture");

endmodule

// file: tb.sv
// Self-checking bench for the alert status bank: APB register reads, sticky latches,
// shutdown outputs and interrupt. Assumes the package and both design files compile first.
`timescale 1ns/10ps
module tb;
    logic                  sys_clk_i  = 1'b0;
    logic                  nrst_i     = 1'b0;
    asl_pkg::asl_apb_req_t req        = '0;
    asl_pkg::asl_apb_rsp_t rsp;
    asl_pkg::asl_cmp_t     cmp        = '0;
    logic                  led_off;
    logic                  conv_off;
    logic                  irq;
    int                    err_count  = 0;
    int                    num_checks = 0;
    int                    seed       = 32'he90ad293;
    logic [9:0]            flag_m     = '0;
    logic [9:0]            sticky_m   = '0;
    logic [10:0]           irq_m      = '0;
    logic [10:0]           mask_m     = '0;
    logic [31:0]           rd;
    logic [31:0]           r1;
    logic [31:0]           r2;
    logic                  er;
    // Alerts that release only when the hold comparator also drops
    localparam logic [9:0] HYST = 10'h03e;

    asl_alert_status_bank DUT (
        .sys_clk_i             (sys_clk_i),
        .nrst_i                (nrst_i),
        .apb_req_i             (req),
        .apb_rsp_o             (rsp),
        .cmp_i                 (cmp),
        .led_driver_off_o      (led_off),
        .second_converter_off_o(conv_off),
        .irq_o                 (irq)
    );

    // 50 MHz clock
    always #10 sys_clk_i = ~sys_clk_i;

    // Expected flag: trip sets, hold keeps only the hysteresis alerts
    function automatic logic [9:0] flag_next(input logic [9:0] f, t, h);
        return t | (f & h & HYST);
    endfunction

    // Alert vector to interrupt layout, bit seven left empty
    function automatic logic [10:0] irq_map(input logic [9:0] v);
        return {v[9:7], 1'b0, v[6:0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until the edge that sees pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= {24'h000000, a};
        req.pwdata  <= wd;
        @(posedge sys_clk_i);
        req.penable <= 1'b1;
        // Read at the rising edge itself, before the design's flops move
        @(posedge sys_clk_i);
        while (rsp.pready !== 1'b1 && n < 100) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n >= 100) begin
            err_count++;
            $display("ERROR t=%0t no pready", $time);
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
        chk({31'h0, er}, 32'h00000000);
    endtask

    // Drive comparators, let synchronisers settle, update the model
    task automatic set_alerts(input logic [9:0] t, input logic [9:0] h);
        logic [9:0] nf;
        @(posedge sys_clk_i);
        cmp.trip <= t;
        cmp.hold <= h;
        repeat (10) @(posedge sys_clk_i);
        nf       = flag_next(flag_m, t, h);
        sticky_m = sticky_m | (nf & ~flag_m);
        irq_m    = irq_m | irq_map(nf & ~flag_m);
        flag_m   = nf;
        @(negedge sys_clk_i);
        chk({31'h0, led_off}, {31'h0, flag_m[9] | flag_m[8]});
        chk({31'h0, conv_off}, {31'h0, flag_m[7]});
    endtask

    // Live view, then both sticky latches, which clear on read
    task automatic read_all();
        rd_chk(asl_pkg::LIVE_OFF, {29'h0, flag_m[9:7]});
        rd_chk(asl_pkg::LATCH_A_OFF, {25'h0, sticky_m[6:0]});
        rd_chk(asl_pkg::LATCH_B_OFF, {29'h0, sticky_m[9:7]});
        sticky_m = '0;
    endtask

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #(30000 * 20);
        err_count++;
        $display("ERROR t=%0t watchdog expired", $time);
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        read_all();
        rd_chk(asl_pkg::IRQ_ST_OFF, 32'h00000000);
        apb(1'b0, 8'h40, 32'h00000000);
        chk({31'h0, er}, 32'h00000001);
        chk(rd, 32'h00000000);
        // Desat held, writes to read-only places ignored, then read clears
        set_alerts(10'h100, 10'h000);
        apb(1'b1, asl_pkg::LATCH_B_OFF, 32'h000000ff);
        apb(1'b1, asl_pkg::LIVE_OFF, 32'h00000000);
        read_all();
        read_all();
        // Brief overcurrent: live bit gone, sticky bit kept
        set_alerts(10'h200, 10'h000);
        set_alerts(10'h000, 10'h000);
        read_all();
        // Hysteresis: held alerts raise no second edge
        set_alerts(HYST, HYST);
        set_alerts(10'h000, HYST);
        read_all();
        set_alerts(HYST, HYST);
        read_all();
        set_alerts(10'h000, 10'h000);
        apb(1'b1, asl_pkg::IRQ_ST_OFF, 32'h000007ff);
        irq_m = '0;
        // Random phases with masks, clears and skipped reads
        repeat (40) begin
            r1     = $random(seed);
            mask_m = r1[10:0] & 11'h77f;
            apb(1'b1, asl_pkg::IRQ_MSK_OFF, {21'h0, mask_m});
            r1 = $random(seed);
            r2 = $random(seed);
            set_alerts(r1[9:0], r2[9:0]);
            chk({31'h0, irq}, {31'h0, |(irq_m & mask_m)});
            rd_chk(asl_pkg::IRQ_ST_OFF, {21'h0, irq_m});
            rd_chk(asl_pkg::IRQ_MSK_OFF, {21'h0, mask_m});
            r1 = $random(seed);
            apb(1'b1, asl_pkg::IRQ_ST_OFF, r1 & 32'h000007ff);
            irq_m = irq_m & ~r1[10:0];
            if (r1[20])
                read_all();
        end
        // Reset in mid run with events pending
        set_alerts(10'h3ff, 10'h000);
        @(posedge sys_clk_i);
        cmp    <= '0;
        nrst_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        flag_m   = '0;
        sticky_m = '0;
        read_all();
        rd_chk(asl_pkg::IRQ_ST_OFF, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        print_verdict();
    end
endmodule
